// [core/psd_port0_straps.sv]
/*
  Port 0 soft-strap defaults: strap register, virtual partner ability,
  virtual advertisement and manual flow-control registers, and the
  operating speed and duplex of port 0.
  Assumes a plain register port (read data one cycle after the strobe),
  an EEPROM loader that signals completion, and an external PHY driving
  the speed and duplex indications in MAC mode.
*/
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Speed strap sets partner speed ability defaults
// - Failed virtual negotiation runs strap speed
// - Speed and speed polarity share one bit
// - Speed pin decoded by polarity strap
// - Duplex strap sets partner duplex ability defaults
// - Duplex and duplex polarity share one bit
// - Duplex pin decoded by polarity strap
// - Backpressure strap sets backpressure enable default
// - Full-duplex pause strap sets TX/RX enables
// - Same strap sets partner pause defaults
// - Manual pause strap sets advertised pause defaults
// - EEPROM loader overrides every soft strap
module psd_port0_straps
  import psd_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [PSD_ADDR_W-1:0] addr,
  input wire logic [PSD_DATA_W-1:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [PSD_DATA_W-1:0] rdData,
  input wire psd_straps_t strapPins,
  input wire logic eeWrite,
  input wire psd_straps_t eeData,
  input wire logic eeDone,
  input wire logic macMode,
  input wire psd_ind_t ind,
  input wire logic anDone,
  input wire logic anFailed,
  input wire logic anSpeed100,
  input wire logic anFullDuplex,
  output logic opSpeed100,
  output logic opFullDuplex,
  output logic backpressureEn,
  output logic txPauseEn,
  output logic rxPauseEn,
  output logic portReady
);

  psd_straps_t straps;
  logic applyDefaults;
  logic loaderReady;
  logic decSpeed100;
  logic decFullDuplex;
  logic [15:0] virtual_partner_ability_reg;
  logic [15:0] virtual_advertise_reg;
  logic [3:0] port0_manual_flow_reg;
  logic [15:0] partnerDefault;
  logic [15:0] advertDefault;
  logic [3:0] flowDefault;
  logic [15:0] readValue;

  psd_strap_loader loader (
    .clock(clock),
    .rst(rst),
    .strapPins(strapPins),
    .eeWrite(eeWrite),
    .eeData(eeData),
    .eeDone(eeDone),
    .straps(straps),
    .applyDefaults(applyDefaults),
    .portReady(loaderReady)
  );

  // One strap bit serves as both select and polarity
  psd_ind_decode decoder (
    .ind(ind),
    .speedPol(straps.speed),
    .duplexPol(straps.duplex),
    .speed100(decSpeed100),
    .fullDuplex(decFullDuplex)
  );

  // Defaults derived from the current straps
  always_comb begin
    partnerDefault = PSD_SELECTOR_RST;
    partnerDefault[PSD_BIT_100FD] = straps.speed & straps.duplex;
    partnerDefault[PSD_BIT_100HD] = straps.speed & ~straps.duplex;
    partnerDefault[PSD_BIT_10FD] = ~straps.speed & straps.duplex;
    partnerDefault[PSD_BIT_10HD] = ~straps.speed & ~straps.duplex;
    partnerDefault[PSD_BIT_PAUSE] = straps.fdPause;
    partnerDefault[PSD_BIT_ASYM] = straps.fdPause;
  end

  // Manual flow control means pause is not negotiated
  always_comb begin
    advertDefault = PSD_ADVERT_ABIL_RST;
    advertDefault[PSD_BIT_PAUSE] = ~straps.manualPause;
    advertDefault[PSD_BIT_ASYM] = ~straps.manualPause;
  end

  always_comb begin
    flowDefault = 4'h0;
    flowDefault[PSD_FLOW_RXP] = straps.fdPause;
    flowDefault[PSD_FLOW_TXP] = straps.fdPause;
    flowDefault[PSD_FLOW_BP] = straps.backpressure;
    flowDefault[PSD_FLOW_MAN] = straps.manualPause;
  end

  // Reload beats a same-cycle software write
  always_ff @(posedge clock) begin
    if (rst) begin
      virtual_partner_ability_reg <= PSD_SELECTOR_RST;
    end else if (applyDefaults) begin
      virtual_partner_ability_reg <= partnerDefault;
    end else if (wrEn && addr == PSD_OFF_PARTNER) begin
      virtual_partner_ability_reg <= wrData;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      virtual_advertise_reg <= PSD_ADVERT_ABIL_RST;
    end else if (applyDefaults) begin
      virtual_advertise_reg <= advertDefault;
    end else if (wrEn && addr == PSD_OFF_ADVERT) begin
      virtual_advertise_reg <= wrData;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      port0_manual_flow_reg <= 4'h0;
    end else if (applyDefaults) begin
      port0_manual_flow_reg <= flowDefault;
    end else if (wrEn && addr == PSD_OFF_FLOW) begin
      port0_manual_flow_reg <= wrData[3:0];
    end
  end

  // Flow enables follow the register, gated until defaults are in
  always_ff @(posedge clock) begin
    if (rst) begin
      backpressureEn <= 1'b0;
      txPauseEn <= 1'b0;
      rxPauseEn <= 1'b0;
      portReady <= 1'b0;
    end else begin
      backpressureEn <= loaderReady & port0_manual_flow_reg[PSD_FLOW_BP];
      txPauseEn <= loaderReady & port0_manual_flow_reg[PSD_FLOW_TXP];
      rxPauseEn <= loaderReady & port0_manual_flow_reg[PSD_FLOW_RXP];
      portReady <= loaderReady;
    end
  end

  // Operating speed and duplex; held while nothing has resolved them
  always_ff @(posedge clock) begin
    if (rst) begin
      opSpeed100 <= 1'b0;
      opFullDuplex <= 1'b0;
    end else if (loaderReady) begin
      if (macMode) begin
        opSpeed100 <= decSpeed100;
        opFullDuplex <= decFullDuplex;
      end else if (anFailed) begin
        // Parallel detection cannot learn duplex, so half duplex
        opSpeed100 <= straps.speed;
        opFullDuplex <= 1'b0;
      end else if (anDone) begin
        opSpeed100 <= anSpeed100;
        opFullDuplex <= anFullDuplex;
      end
    end
  end

  always_comb begin
    readValue = 16'h0000;
    unique case (addr)
      PSD_OFF_STRAP: readValue = {11'h000, straps};
      PSD_OFF_PARTNER: readValue = virtual_partner_ability_reg;
      PSD_OFF_ADVERT: readValue = virtual_advertise_reg;
      PSD_OFF_FLOW: readValue = {12'h000, port0_manual_flow_reg};
      PSD_OFF_STATUS: begin
        readValue[PSD_STAT_SPEED] = opSpeed100;
        readValue[PSD_STAT_FDX] = opFullDuplex;
        readValue[PSD_STAT_READY] = portReady;
        readValue[PSD_STAT_ANFAIL] = anFailed;
        readValue[PSD_STAT_MAC] = macMode;
      end
      default: readValue = 16'h0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      rdData <= 16'h0000;
    end else if (rdEn) begin
      rdData <= readValue;
    end else begin
      rdData <= 16'h0000;
    end
  end

  default clocking cb @(posedge clock);
  endclocking

  default disable iff (rst);

  sequence reloadPulse;
    applyDefaults ##1 !applyDefaults;
  endsequence

  chk_partner_speed: assert property (
    applyDefaults |=> (virtual_partner_ability_reg[PSD_BIT_100FD] |
      virtual_partner_ability_reg[PSD_BIT_100HD]) == $past(straps.speed))
    else $error("partner speed ability does not follow strap");

  chk_partner_duplex: assert property (
    applyDefaults |=> (virtual_partner_ability_reg[PSD_BIT_100FD] |
      virtual_partner_ability_reg[PSD_BIT_10FD]) == $past(straps.duplex))
    else $error("partner duplex ability does not follow strap");

  chk_partner_pause: assert property (
    reloadPulse |-> virtual_partner_ability_reg[PSD_BIT_ASYM:PSD_BIT_PAUSE]
      == {2{$past(straps.fdPause)}})
    else $error("partner pause bits do not follow strap");

  chk_advert_pause: assert property (
    applyDefaults |=> virtual_advertise_reg[PSD_BIT_PAUSE] ==
      !$past(straps.manualPause) && virtual_advertise_reg[PSD_BIT_ASYM] ==
      !$past(straps.manualPause))
    else $error("advertised pause bits do not follow strap");

  chk_flow_backpress: assert property (
    applyDefaults ##1 loaderReady |=> backpressureEn == $past(straps
      .backpressure, 2))
    else $error("backpressure enable does not follow strap");

  chk_flow_fdpause: assert property (
    applyDefaults |=> port0_manual_flow_reg[PSD_FLOW_RXP] ==
      $past(straps.fdPause) && port0_manual_flow_reg[PSD_FLOW_TXP] ==
      $past(straps.fdPause))
    else $error("pause enables do not follow strap");

  chk_fallback_speed: assert property (
    loaderReady && !macMode && anFailed |=> opSpeed100 == $past(straps.speed)
      && !opFullDuplex)
    else $error("failed negotiation did not use strap speed");

  chk_speed_decode: assert property (
    loaderReady && macMode |=> opSpeed100 ==
      ($past(ind.speedPin) == $past(straps.speed)))
    else $error("speed indication decoded with wrong polarity");

  chk_duplex_decode: assert property (
    loaderReady && macMode |=> opFullDuplex ==
      ($past(ind.duplexPin) == $past(straps.duplex)))
    else $error("duplex indication decoded with wrong polarity");

  chk_ready_after_load: assert property (
    portReady |-> $past(loaderReady))
    else $error("port ready before defaults applied");

  chk_read_unmapped: assert property (
    rdEn && addr > PSD_OFF_STATUS |=> rdData == 16'h0000)
    else $error("unmapped read not zero");

  // Register port answers
  sequence statusRead;
    rdEn && addr == PSD_OFF_STATUS;
  endsequence

  chk_rd_idle: assert property (
    !rdEn |=>
      rdData == 16'h0000)
    else $error("read data not zero outside a read");

  chk_rd_status: assert property (
    statusRead |=> rdData[PSD_STAT_READY] == $past(portReady) &&
      rdData[PSD_STAT_MAC] == $past(macMode))
    else $error("status ready or mode bit wrong");

  chk_rd_op: assert property (
    statusRead |=> rdData[PSD_STAT_SPEED] == $past(opSpeed100) &&
      rdData[PSD_STAT_FDX] == $past(opFullDuplex))
    else $error("status speed or duplex bit wrong");

  chk_rd_strap: assert property (
    rdEn && addr == PSD_OFF_STRAP |=> rdData ==
      {11'h000, $past(straps)})
    else $error("strap register read wrong");

  chk_strap_duplex: assert property (
    rdEn && addr == PSD_OFF_STRAP |=>
      rdData[1] == $past(straps.duplex))
    else $error("duplex strap bit read wrong");

  chk_enables_gated: assert property (
    !loaderReady |=>
      !backpressureEn && !txPauseEn && !rxPauseEn)
    else $error("flow enables active before defaults");

  chk_flow_write: assert property (
    wrEn && addr == PSD_OFF_FLOW && !applyDefaults |=>
      port0_manual_flow_reg == $past(wrData[3:0]))
    else $error("flow register write lost");

  chk_partner_write: assert property (
    wrEn && addr == PSD_OFF_PARTNER && !applyDefaults |=>
      virtual_partner_ability_reg == $past(wrData))
    else $error("partner register write lost");

  chk_advert_write: assert property (
    wrEn && addr == PSD_OFF_ADVERT && !applyDefaults |=>
      virtual_advertise_reg == $past(wrData))
    else $error("advertisement register write lost");

  chk_partner_onehot: assert property (
    applyDefaults |=>
      $onehot(virtual_partner_ability_reg[PSD_BIT_100FD:PSD_BIT_10HD]))
    else $error("partner default not a single ability");

  chk_advert_base: assert property (
    applyDefaults |=>
      virtual_advertise_reg[9:0] == PSD_ADVERT_ABIL_RST[9:0])
    else $error("advertised abilities not at default");

  chk_op_hold: assert property (
    loaderReady && !macMode && !anFailed && !anDone |=>
      $stable(opSpeed100) && $stable(opFullDuplex))
    else $error("operating mode moved without a cause");

  chk_idle_hold: assert property (
    !loaderReady |=>
      $stable(opSpeed100) && $stable(opFullDuplex))
    else $error("operating mode moved before defaults");

endmodule
`default_nettype wire

// [core/psd_pkg.sv]
/*
  Constants and carrier types for the port 0 soft-strap default logic:
  register offsets, field positions, reset values and loader states.
  Assumes a plain register port with 8-bit addresses and 16-bit data.
*/
package psd_pkg;

  localparam int PSD_ADDR_W = 8;
  localparam int PSD_DATA_W = 16;

  // Register offsets
  localparam logic [7:0] PSD_OFF_STRAP = 8'h00;
  localparam logic [7:0] PSD_OFF_PARTNER = 8'h04;
  localparam logic [7:0] PSD_OFF_ADVERT = 8'h08;
  localparam logic [7:0] PSD_OFF_FLOW = 8'h0C;
  localparam logic [7:0] PSD_OFF_STATUS = 8'h10;

  // Ability fields, shared by the partner and advertisement registers
  localparam int PSD_BIT_10HD = 5;
  localparam int PSD_BIT_10FD = 6;
  localparam int PSD_BIT_100HD = 7;
  localparam int PSD_BIT_100FD = 8;
  localparam int PSD_BIT_PAUSE = 10;
  localparam int PSD_BIT_ASYM = 11;
  localparam logic [15:0] PSD_SELECTOR_RST = 16'h0001;
  localparam logic [15:0] PSD_ADVERT_ABIL_RST = 16'h01E1;

  // Manual flow-control register fields
  localparam int PSD_FLOW_RXP = 0;
  localparam int PSD_FLOW_TXP = 1;
  localparam int PSD_FLOW_BP = 2;
  localparam int PSD_FLOW_MAN = 3;

  // Status register fields
  localparam int PSD_STAT_SPEED = 0;
  localparam int PSD_STAT_FDX = 1;
  localparam int PSD_STAT_READY = 2;
  localparam int PSD_STAT_ANFAIL = 3;
  localparam int PSD_STAT_MAC = 4;

  // Soft-strap set; speed and duplex double as the polarity straps
  typedef struct packed {
    logic manualPause;
    logic fdPause;
    logic backpressure;
    logic duplex;
    logic speed;
  } psd_straps_t;

  localparam psd_straps_t PSD_STRAP_RST = 5'h0F;

  // Speed and duplex indications from the external PHY
  typedef struct packed {
    logic speedPin;
    logic duplexPin;
  } psd_ind_t;

  typedef enum logic [1:0] {
    PSD_LATCH,
    PSD_WAIT_EE,
    PSD_APPLY,
    PSD_RUN
  } psd_load_t;

endpackage

// [core/psd_strap_loader.sv]
/*
  Soft-strap holder: latches strap pins after reset, accepts EEPROM
  loader overrides, and pulses a reload of register defaults.
  Assumes strap pins are stable in the cycle after reset release.
*/
`timescale 1ns/1ns
`default_nettype none
module psd_strap_loader
  import psd_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire psd_straps_t strapPins,
  input wire logic eeWrite,
  input wire psd_straps_t eeData,
  input wire logic eeDone,
  output psd_straps_t straps,
  output logic applyDefaults,
  output logic portReady
);

  psd_load_t state_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= PSD_LATCH;
    end else begin
      unique case (state_r)
        PSD_LATCH: state_r <= PSD_WAIT_EE;
        PSD_WAIT_EE: if (eeDone) state_r <= PSD_APPLY;
        PSD_APPLY: state_r <= PSD_RUN;
        // A later EEPROM reload restores defaults again
        PSD_RUN: if (eeWrite) state_r <= PSD_APPLY;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      straps <= PSD_STRAP_RST;
    end else if (eeWrite) begin
      straps <= eeData;
    end else if (state_r == PSD_LATCH) begin
      straps <= strapPins;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      applyDefaults <= 1'b0;
      portReady <= 1'b0;
    end else begin
      applyDefaults <= (state_r == PSD_WAIT_EE && eeDone) ||
                       (state_r == PSD_RUN && eeWrite);
      portReady <= (state_r == PSD_APPLY) ||
                   (state_r == PSD_RUN && !eeWrite);
    end
  end

  sequence loadFinished;
    state_r == PSD_WAIT_EE && eeDone && !eeWrite;
  endsequence

  sequence defaultsThenRun;
    applyDefaults ##1 portReady;
  endsequence

  chk_apply_before_run: assert property (@(posedge clock) disable iff (rst)
    loadFinished |=> defaultsThenRun)
    else $error("defaults not applied before normal operation");

  chk_ee_override: assert property (@(posedge clock) disable iff (rst)
    eeWrite |=> straps == $past(eeData))
    else $error("EEPROM value did not override strap");

endmodule
`default_nettype wire

// [core/psd_ind_decode.sv]
/*
  Polarity decoder for the port 0 speed and duplex indication inputs.
  Assumes the polarity bits are the shared speed and duplex straps.
*/
`timescale 1ns/1ns
`default_nettype none
module psd_ind_decode
  import psd_pkg::*;
(
  input wire psd_ind_t ind,
  input wire logic speedPol,
  input wire logic duplexPol,
  output logic speed100,
  output logic fullDuplex
);

  // Polarity 1 means a high pin selects 100 Mbit or full duplex
  always_comb begin
    speed100 = ~(ind.speedPin ^ speedPol);
    fullDuplex = ~(ind.duplexPin ^ duplexPol);
  end

endmodule
`default_nettype wire

// [test/psd_phy_model.sv]
/*
  External PHY model driving the port 0 speed and duplex indications.
  Assumes the bench gives the board polarity and the link to report.
*/
`timescale 1ns/1ns
`default_nettype none
module psd_phy_model
  import psd_pkg::*;
(
  input wire logic clock,
  input wire logic linkSpeed100,
  input wire logic linkFull,
  input wire logic speedPol,
  input wire logic duplexPol,
  input wire logic slow,
  output psd_ind_t ind
);
  psd_ind_t stage_r;
  psd_ind_t late_r;
  // Pins move only after an edge; slow adds a cycle of lag
  always_ff @(posedge clock) begin
    stage_r.speedPin <= speedPol ? linkSpeed100 : ~linkSpeed100;
    stage_r.duplexPin <= duplexPol ? linkFull : ~linkFull;
    late_r <= stage_r;
  end
  assign ind = slow ? late_r : stage_r;
endmodule
`default_nettype wire

// [test/psd_port0_straps_tb.sv]
/*
  Self-checking bench for the port 0 soft-strap defaults.
  Assumes the package offsets and the hand-over timing of the loader.
*/
`timescale 1ns/1ns
`default_nettype none
module psd_port0_straps_tb
  import psd_pkg::*;
;
  logic clock = 1'b0;
  logic rst, wrEn, rdEn, eeWrite, eeDone, macMode, anDone, anFailed;
  logic anSpeed100, anFullDuplex, linkSpeed100, linkFull, slow;
  logic opSpeed100, opFullDuplex, backpressureEn, txPauseEn, rxPauseEn;
  logic portReady;
  logic [7:0] addr;
  logic [15:0] wrData, rdData, d;
  logic [31:0] seed = 32'h00001C6B;
  logic [31:0] r;
  psd_straps_t strapPins, eeData, s;
  psd_ind_t ind;
  int errors = 0;
  int checked = 0;
  int cycles = 0;

  psd_port0_straps psd_port0_straps_i (.clock(clock), .rst(rst),
    .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
    .rdData(rdData), .strapPins(strapPins), .eeWrite(eeWrite),
    .eeData(eeData), .eeDone(eeDone), .macMode(macMode), .ind(ind),
    .anDone(anDone), .anFailed(anFailed), .anSpeed100(anSpeed100),
    .anFullDuplex(anFullDuplex), .opSpeed100(opSpeed100),
    .opFullDuplex(opFullDuplex), .backpressureEn(backpressureEn),
    .txPauseEn(txPauseEn), .rxPauseEn(rxPauseEn), .portReady(portReady));

  psd_phy_model psd_phy_model_i (.clock(clock),
    .linkSpeed100(linkSpeed100), .linkFull(linkFull),
    .speedPol(s.speed), .duplexPol(s.duplex), .slow(slow), .ind(ind));

  initial begin
    forever #50 clock = ~clock;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [15:0] partnerExp(input psd_straps_t t);
    logic [15:0] v;
    v = PSD_SELECTOR_RST;
    case ({t.speed, t.duplex})
      2'b11: v[PSD_BIT_100FD] = 1'b1;
      2'b10: v[PSD_BIT_100HD] = 1'b1;
      2'b01: v[PSD_BIT_10FD] = 1'b1;
      default: v[PSD_BIT_10HD] = 1'b1;
    endcase
    v[PSD_BIT_PAUSE] = t.fdPause;
    v[PSD_BIT_ASYM] = t.fdPause;
    return v;
  endfunction

  function automatic logic [15:0] advertExp(input psd_straps_t t);
    logic [15:0] v;
    v = PSD_ADVERT_ABIL_RST;
    v[PSD_BIT_PAUSE] = ~t.manualPause;
    v[PSD_BIT_ASYM] = ~t.manualPause;
    return v;
  endfunction

  function automatic logic [15:0] flowExp(input psd_straps_t t);
    return {13'h0000, t.backpressure, t.fdPause, t.fdPause};
  endfunction

  task automatic finish_test();
    if (errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clock);
    addr <= a;
    wrData <= v;
    wrEn <= 1'b1;
    @(posedge clock);
    wrEn <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clock);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clock);
    rdEn <= 1'b0;
    #1 v = rdData;
  endtask

  task automatic waitReady(input logic lvl);
    int n;
    n = 0;
    #1;
    while (portReady !== lvl && n < 20) begin
      @(posedge clock);
      #1 n++;
    end
    chk(16'(portReady), 16'(lvl));
  endtask

  // Pins flip after the latch edge, so a late resample shows up
  task automatic start(input psd_straps_t pins, input logic useEe,
                       input psd_straps_t ee);
    @(posedge clock);
    rst <= 1'b1;
    eeDone <= 1'b0;
    strapPins <= pins;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    strapPins <= ~pins;
    eeData <= ee;
    eeWrite <= useEe;
    @(posedge clock);
    eeWrite <= 1'b0;
    eeDone <= 1'b1;
    waitReady(1'b1);
  endtask

  task automatic checkDefaults();
    rd(PSD_OFF_PARTNER, d);
    chk(d, partnerExp(s));
    rd(PSD_OFF_ADVERT, d);
    chk(d, advertExp(s));
    rd(PSD_OFF_FLOW, d);
    chk({13'h0000, d[2:0]}, flowExp(s));
    chk(16'({backpressureEn, txPauseEn, rxPauseEn}), flowExp(s));
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 10000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    {rst, wrEn, rdEn, eeWrite, eeDone, macMode, anDone, anFailed} = 8'h80;
    {anSpeed100, anFullDuplex, linkSpeed100, linkFull, slow} = 5'h00;
    addr = 8'h00;
    wrData = 16'h0000;
    strapPins = PSD_STRAP_RST;
    eeData = PSD_STRAP_RST;
    s = PSD_STRAP_RST;
    for (int i = 0; i < 32; i++) begin
      r = rnd();
      start(psd_straps_t'(i[4:0]), r[5], r[4:0]);
      s = r[5] ? psd_straps_t'(r[4:0]) : psd_straps_t'(i[4:0]);
      checkDefaults();
      wr(PSD_OFF_STRAP, 16'hFFFF);
      rd(PSD_OFF_STRAP, d);
      chk(d, 16'(s));
      rd(8'h14, d);
      chk(d, 16'h0000);
      @(posedge clock);
      slow <= r[6];
      macMode <= 1'b1;
      for (int k = 0; k < 4; k++) begin
        linkSpeed100 <= k[0];
        linkFull <= k[1];
        repeat (4) @(posedge clock);
        #1 chk(16'({opSpeed100, opFullDuplex}), 16'({k[0], k[1]}));
      end
      macMode <= 1'b0;
      anFailed <= 1'b1;
      anDone <= 1'b1;
      anSpeed100 <= ~s.speed;
      repeat (2) @(posedge clock);
      #1 chk(16'({opSpeed100, opFullDuplex}), 16'({s.speed, 1'b0}));
      anFailed <= 1'b0;
      anSpeed100 <= r[8];
      anFullDuplex <= r[9];
      repeat (2) @(posedge clock);
      #1 chk(16'({opSpeed100, opFullDuplex}), 16'({r[8], r[9]}));
      anDone <= 1'b0;
      wr(PSD_OFF_FLOW, {12'h000, r[13:10]});
      rd(PSD_OFF_FLOW, d);
      chk(d, {12'h000, r[13:10]});
      chk(16'({backpressureEn, txPauseEn, rxPauseEn}), 16'(r[12:10]));
      // Reload in run state must restore the defaults just overwritten
      @(posedge clock);
      eeData <= ~s;
      eeWrite <= 1'b1;
      @(posedge clock);
      eeWrite <= 1'b0;
      s = ~s;
      waitReady(1'b0);
      waitReady(1'b1);
      checkDefaults();
    end
    finish_test();
  end
endmodule
`default_nettype wire
